// *** rtl/ipc_pkg.sv ***
// Purpose: Constants for the interrupt pending set and clear block
// Assumes: Avalon-MM slave with 32-bit data, word addressing in bytes
// Notes: Offsets are byte addresses of aligned words
package ipc_pkg;
  localparam int IPC_NUM_IRQ = 32;
  localparam int IPC_ADDR_W = 4;
  localparam logic [3:0] IPC_OFS_SET = 4'h0;
  localparam logic [3:0] IPC_OFS_CLR = 4'h4;
  localparam logic [3:0] IPC_OFS_ENABLE = 4'h8;
  localparam logic [3:0] IPC_OFS_ACTIVE = 4'hc;
  localparam logic [31:0] IPC_ENABLE_RST = 32'h00000000;
  localparam logic [31:0] IPC_RDATA_RST = 32'h00000000;
  localparam logic [31:0] IPC_UNMAPPED_RD = 32'h00000000;
endpackage

// *** rtl/ipc_pending.sv ***
// Purpose: Shared pending state with set and clear register views
// Assumes: Same-clock interrupt sources and active flags from the core
// Notes: Every access answers one cycle after it is presented, and a
// write acts only on the edge where waitrequest is low
//
// What this block does
// - One clear bit per interrupt 0 to 31
// - Writing one clears that interrupt's pending state
// - Clear ignored while interrupt is being serviced
// - Zero bits written change nothing
// - Read returns current pending bits
// - Set and clear views share one state
// - Set pends unless already pending or disabled
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
module ipc_pending (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [ipc_pkg::IPC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources and core state
  input wire logic [ipc_pkg::IPC_NUM_IRQ-1:0] irq_req,
  input wire logic [ipc_pkg::IPC_NUM_IRQ-1:0] irq_active,
  output logic [ipc_pkg::IPC_NUM_IRQ-1:0] irq_pending
);
  import ipc_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Widen the byte enables to one mask bit per data bit
  function automatic logic [31:0] ipc_be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // Next value of one pending bit
  function automatic logic ipc_next_pend(
    input logic cur,
    input logic raise,
    input logic drop,
    input logic enabled,
    input logic active
  );
    logic keep;
    logic gain;
    keep = cur & ~(drop & ~active);
    gain = raise & enabled & ~cur;
    return keep | gain;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------

  // Bus handshake
  logic req;
  logic take;
  logic wr_commit;
  logic ack_q;
  logic ack_d;
  logic wait_q;
  logic wait_d;

  // Enable and read data
  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Write decode
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [IPC_NUM_IRQ-1:0] set_bits;
  logic [IPC_NUM_IRQ-1:0] clr_bits;

  // Pending state
  logic [IPC_NUM_IRQ-1:0] pend_q;
  logic [IPC_NUM_IRQ-1:0] pend_d;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------

  // Taken while idle, completes one cycle later where waitrequest is low
  // Writes act only at that completing edge
  always_comb begin
    req = avs_read | avs_write;
    take = req & ~ack_q;
    wr_commit = avs_write & ack_q;
    ack_d = take;
    wait_d = ~take;
  end

  // Handshake flops
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      wait_q <= 1'b1;
    end else begin
      ack_q <= ack_d;
      wait_q <= wait_d;
    end
  end

  // ----------------------------------------
  // Write data masking
  // ----------------------------------------

  always_comb begin
    wmask = ipc_be_mask(avs_byteenable);
    wbits = avs_writedata & wmask;
  end

  // ----------------------------------------
  // Write decode
  // ----------------------------------------

  // Only the completing edge of a write changes state
  always_comb begin
    set_bits = '0;
    clr_bits = '0;
    enable_d = enable_q;
    if (wr_commit) begin
      unique case (avs_address)
        IPC_OFS_SET: begin
          set_bits = wbits;
        end
        IPC_OFS_CLR: begin
          clr_bits = wbits;
        end
        IPC_OFS_ENABLE: begin
          enable_d = (enable_q & ~wmask) | wbits;
        end
        default: begin
          // Active view and unmapped words ignore writes
        end
      endcase
    end
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      enable_q <= IPC_ENABLE_RST;
    end else begin
      enable_q <= enable_d;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------

  // Captured when taken, stands while waitrequest is low
  // Returns to zero after that cycle
  always_comb begin
    rdata_d = IPC_RDATA_RST;
    if (take && avs_read) begin
      unique case (avs_address)
        IPC_OFS_SET: begin
          rdata_d = pend_q;
        end
        IPC_OFS_CLR: begin
          rdata_d = pend_q;
        end
        IPC_OFS_ENABLE: begin
          rdata_d = enable_q;
        end
        IPC_OFS_ACTIVE: begin
          rdata_d = irq_active;
        end
        default: begin
          rdata_d = IPC_UNMAPPED_RD;
        end
      endcase
    end
  end

  // Read data flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata_q <= IPC_RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Pending state
  // ----------------------------------------

  // One flop per interrupt, shared by set and clear views
  // No reset: a bit stays unknown until first set or cleared
  generate
    for (genvar i = 0; i < IPC_NUM_IRQ; i++) begin : g_irq
      // Next state
      always_comb begin
        pend_d[i] = ipc_next_pend(pend_q[i], irq_req[i] | set_bits[i],
                                  clr_bits[i], enable_q[i], irq_active[i]);
      end

      // Register
      always_ff @(posedge clk_sys) begin
        pend_q[i] <= pend_d[i];
      end
    end
  endgenerate

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  // Every output is a flop
  always_comb begin
    avs_readdata = rdata_q;
    avs_waitrequest = wait_q;
    irq_pending = pend_q;
  end
endmodule

// *** bench/ipc_src.sv ***
// Purpose: sources, core. Assumes: same clock. Notes: bench-driven
module ipc_src (
  input logic [31:0] pulse, busy,
  output logic [31:0] irq_req, irq_active);
  timeunit 1ns; timeprecision 100ps;
  assign irq_req = pulse;
  assign irq_active = busy;
endmodule

// *** bench/ipc_pending_sva.sv ***
// Purpose: port checks. Assumes: full bytes. Notes: bound below
module ipc_sva (
  input logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest,
  input logic [3:0] avs_address, avs_byteenable,
  input logic [31:0] avs_writedata, avs_readdata,
  input logic [31:0] irq_req, irq_active, irq_pending);
  timeunit 1ns; timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire t = (avs_read || avs_write) && avs_waitrequest;
  wire f = avs_write && !avs_waitrequest && avs_byteenable == 4'hf;
  wire c = f && avs_address == 4'h4;
  wire s = f && avs_address == 4'h0;
  wire r = avs_read && avs_waitrequest;
  wire v = r && (avs_address == 4'h0 || avs_address == 4'h4);
  wire [31:0] p = irq_pending;
  wire [31:0] m = avs_writedata & ~irq_active & ~irq_req;
  property p_clr; c |=> (p & $past(m)) == '0; endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_act; c |=> (~p & $past(p & irq_active)) == '0; endproperty
  a_act: assert property (p_act) else $error("act");
  property p_zero; c |=> (~p & $past(p & ~avs_writedata)) == '0; endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_rd; v |=> avs_readdata == $past(p); endproperty
  a_rd: assert property (p_rd) else $error("rd");
  property p_set; s |=> (~p & $past(p)) == '0; endproperty
  a_set: assert property (p_set) else $error("set");
  property p_wait; t |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_idle; avs_waitrequest |-> avs_readdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_unm; r && avs_address == 4'h2 |=> avs_readdata == '0; endproperty
  a_unm: assert property (p_unm) else $error("unm");
endmodule
bind ipc_pending ipc_sva u_sva (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .avs_address(avs_address),
  .avs_byteenable(avs_byteenable),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .irq_req(irq_req),
  .irq_active(irq_active),
  .irq_pending(irq_pending)
);

// *** bench/test_interrupt_pending_clear.sv ***
// Purpose: register tests. Assumes: enable at 0x8. Notes: none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module test_interrupt_pending_clear;
  timeunit 1ns; timeprecision 100ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = '0, pulse = '0, busy = '0, rdat;
  logic [31:0] avs_readdata, irq_req, irq_active, irq_pending;
  int checked = 0, fail_count = 0, cyc = 0;
  ipc_pending dut (.*);
  ipc_src src (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 2000) begin fail_count++; test_done(); end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(rdat, e)
  endtask
  task automatic test_done();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    bus(1'b1, 4'h8, '1);
    bus(1'b1, 4'h4, '1);
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h0, 32'h80000001);
    rd(4'h0, 32'h80000001);
    rd(4'h4, 32'h80000001);
    busy <= 32'h1;
    rd(4'hc, 32'h1);
    bus(1'b1, 4'h4, '1);
    rd(4'h4, 32'h1);
    busy <= '0;
    bus(1'b1, 4'h4, '0);
    rd(4'h4, 32'h1);
    bus(1'b1, 4'h4, 32'h1);
    rd(4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'h00000100);
    avs_byteenable <= 4'h1;
    bus(1'b1, 4'h4, '1);
    rd(4'h4, 32'h00000100);
    avs_byteenable <= 4'h2;
    bus(1'b1, 4'h4, '1);
    avs_byteenable <= 4'hf;
    rd(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h4);
    rd(4'h8, 32'h4);
    bus(1'b1, 4'h0, 32'h3);
    pulse <= 32'h5;
    @(posedge clk_sys);
    pulse <= '0;
    rd(4'h0, 32'h4);
    rd(4'h2, 32'h0);
    $display("test pending done");
    test_done();
  end
endmodule
